// ---- tb_top.sv ----
// Self-checking bench for the video input and frame latency block.
// Assumes the source model file is compiled before this one.
`timescale 1ns/100ps
module tb_top;
    logic                 clk, reset, bpc12, stereo, hold, out_ready, display_frame;
    logic                 pix_valid, pix_ready, pix_sof, pix_eol, out_valid;
    logic                 deinterlacer_on, mode_err, size_err;
    logic [3:0]           frame_ratio;
    logic [1:0]           byte_mode;
    logic [35:0]          pix_data;
    logic [29:0]          out_data;
    logic [5:0]           frc_frames, fmt_frames, total_frames;
    vifl_pkg::vifl_kind_e source_kind;
    int                   n_errors = 0;
    int                   num_checks = 0;

    // Clock of 20 ns period.
    always #10 clk = ~clk;

    vifl_top i_vifl_top (.clk(clk), .reset(reset), .source_kind(source_kind),
        .frame_ratio(frame_ratio), .byte_mode(byte_mode), .bpc12(bpc12), .stereo(stereo),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof),
        .pix_eol(pix_eol), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .display_frame(display_frame), .deinterlacer_on(deinterlacer_on),
        .frc_frames(frc_frames), .fmt_frames(fmt_frames), .total_frames(total_frames),
        .mode_err(mode_err), .size_err(size_err));
    vifl_src_model i_vifl_src_model (.clk(clk), .hold(hold), .pix_ready(pix_ready),
        .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof), .pix_eol(pix_eol));

    // Prints the verdict and ends the run.
    task automatic final_report;
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Compares one flag.
    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // Compares one multi-bit value.
    task automatic chk_val(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Resets for three cycles and checks the idle figures.
    task automatic do_reset;
        @(posedge clk) reset <= 1'h1;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(negedge clk);
        chk_bit(out_valid, 1'h0, "out_valid after reset");
        chk_val(36'(total_frames), 36'h2, "total after reset");
        chk_bit(size_err, 1'h0, "size_err after reset");
    endtask

    // Waits, bounded, until every queued beat has left the block.
    task automatic wait_idle;
        int i;
        for (i = 0; i < 5000; i++) begin
            @(negedge clk);
            if (i_vifl_src_model.q.size() == 0 && pix_valid === 1'h0 && out_valid === 1'h0) break;
        end
        if (i == 5000) begin
            n_errors++;
            $display("wrong value at %0t: drain timed out", $time);
            final_report();
        end
    endtask

    // Fills the buffer while stalled, then drains and checks truncation and order.
    task automatic sc_buffer;
        logic [35:0] w[4] = '{36'hfed_cba_987, 36'h123_456_789, 36'h0ff_f00_a5c, 36'hf_2345_6789};
        int          k;
        int          i;
        @(posedge clk) bpc12 <= 1'h1;
        out_ready <= 1'h0;
        hold <= 1'h1;
        @(negedge clk);
        for (k = 0; k < 3; k++) i_vifl_src_model.push(w[k], k == 0);
        repeat (3) @(negedge clk);
        chk_bit(out_valid, 1'h0, "nothing offered while held");
        @(posedge clk) hold <= 1'h0;
        repeat (5) @(negedge clk);
        chk_bit(pix_ready, 1'h0, "full buffer refuses");
        chk_bit(out_valid, 1'h1, "stalled word stands");
        @(posedge clk) out_ready <= 1'h1;
        k = 0;
        for (i = 0; i < 20 && k < 3; i++) begin
            @(negedge clk);
            if (out_valid === 1'h1) begin
                chk_val(36'(out_data), {6'h0, w[k][35:26], w[k][23:14], w[k][11:2]}, "pix");
                k++;
            end
        end
        chk_val(36'(k), 36'h3, "words delivered");
        // A ten-bit word is held at the output so it is seen while it stands.
        @(posedge clk) bpc12 <= 1'h0;
        out_ready <= 1'h0;
        @(negedge clk) i_vifl_src_model.push(w[3], 1'h0);
        repeat (4) @(negedge clk);
        chk_bit(out_valid, 1'h1, "ten bit word offered");
        chk_val(36'(out_data), 36'(w[3][29:0]), "ten bit word passes");
        @(posedge clk) out_ready <= 1'h1;
        wait_idle();
    endtask

    // Sets every packing mode, then the illegal code, which must hold a beat off.
    task automatic sc_modes;
        logic [1:0] m[4] = '{vifl_pkg::BYTE_MODE_3, vifl_pkg::BYTE_MODE_4,
                             vifl_pkg::BYTE_MODE_5, 2'h3};
        int         k;
        for (k = 0; k < 4; k++) begin
            @(posedge clk) byte_mode <= m[k];
            @(negedge clk);
            chk_bit(mode_err, k == 3, "mode_err");
            chk_bit(pix_ready, k != 3, "pix_ready per mode");
        end
        i_vifl_src_model.push(36'h0_0000_0abc, 1'h0);
        repeat (4) @(negedge clk);
        chk_bit(out_valid, 1'h0, "illegal mode takes nothing");
        @(posedge clk) byte_mode <= vifl_pkg::BYTE_MODE_3;
        wait_idle();
    endtask

    // Runs a 1921-beat 2D line, then the per-eye width limit and its clearing.
    task automatic sc_size;
        int k;
        for (k = 0; k < 1921; k++) i_vifl_src_model.push(36'(k), k == 0);
        wait_idle();
        chk_bit(size_err, 1'h0, "2D line of 1921 beats");
        @(posedge clk) stereo <= 1'h1;
        for (k = 0; k < 1920; k++) i_vifl_src_model.push(36'(k), k == 0);
        wait_idle();
        chk_bit(size_err, 1'h0, "eye line at limit");
        i_vifl_src_model.push(36'h5, 1'h0);
        wait_idle();
        chk_bit(size_err, 1'h1, "eye line over limit");
        i_vifl_src_model.push(36'h6, 1'h1);
        wait_idle();
        chk_bit(size_err, 1'h0, "new frame clears");
        // One-beat lines up to the per-eye height, then one beat beyond it.
        for (k = 0; k < 1080; k++) i_vifl_src_model.push(36'(k), k == 0, 1'h1);
        wait_idle();
        chk_bit(size_err, 1'h0, "eye height at limit");
        i_vifl_src_model.push(36'h7, 1'h0);
        wait_idle();
        chk_bit(size_err, 1'h1, "eye height over limit");
    endtask

    // Steps every source kind through its latency phases.
    task automatic sc_latency;
        vifl_pkg::vifl_kind_e kd[5] = '{vifl_pkg::VIFL_ASYNC_UP, vifl_pkg::VIFL_SYNC_GFX,
            vifl_pkg::VIFL_ASYNC_DOWN, vifl_pkg::VIFL_SYNC_UP, vifl_pkg::VIFL_SYNC_VID};
        int                   nn[5] = '{2, 1, 3, 2, 1};
        int                   k, p, e;
        logic [5:0]           xd, xc, xf;
        for (k = 0; k < 5; k++) begin
            do_reset();
            @(posedge clk) source_kind <= kd[k];
            frame_ratio <= 4'(nn[k]);
            for (p = 1; p < 6; p++) begin
                @(posedge clk) display_frame <= 1'h1;
                @(posedge clk) display_frame <= 1'h0;
                @(negedge clk);
                e = p % (nn[k] + 1);
                case (k)
                    0: {xd, xc, xf} = {6'h0, 6'(1 + e), 6'(nn[k])};
                    1: {xd, xc, xf} = {6'h0, 6'h1, 6'h1};
                    2: {xd, xc, xf} = {6'h0, 6'(e), 6'(nn[k])};
                    3: {xd, xc, xf} = {6'h1, 6'h1, 6'(nn[k])};
                    default: {xd, xc, xf} = {6'h1, 6'h1, 6'h1};
                endcase
                chk_bit(deinterlacer_on, xd[0], "deinterlacer_on");
                chk_val(36'(frc_frames), 36'(xc), "frc_frames");
                chk_val(36'(fmt_frames), 36'(xf), "fmt_frames");
                chk_val(36'(total_frames), 36'(xd + xc + xf), "total_frames");
            end
        end
    endtask

    // Main sequence.
    initial begin
        clk = 1'h0;
        reset = 1'h1;
        source_kind = vifl_pkg::VIFL_SYNC_GFX;
        frame_ratio = 4'h1;
        byte_mode = vifl_pkg::BYTE_MODE_3;
        {bpc12, stereo, hold, out_ready, display_frame} = 5'h0;
        do_reset();
        sc_buffer();
        sc_modes();
        sc_size();
        sc_latency();
        final_report();
    end
endmodule // tb_top

// ---- vifl_buf.sv ----
// Two-entry valid/ready buffer with honest full and empty.
// Assumes the owner drives the user side of the carrier on the same clock.
`timescale 1ns/100ps
module vifl_buf #(
    parameter int unsigned W     = 30,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Buffer ports.
    vifl_buf_if.buf_side bus
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // Handshakes: refuse while full, offer while not empty.
    assign bus.in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign bus.out_valid = (cnt_q != '0);
    assign bus.out_data  = mem_q[rd_q];
    assign push = bus.in_valid && bus.in_ready;
    assign pop  = bus.out_valid && bus.out_ready;

    // Next pointers, fill count and stored words.
    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        if (push) begin
            mem_d[wr_q] = bus.in_data;
            wr_d = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    // Register the buffer state.
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    // The fill count never passes the depth.
    a_buf_no_overfill: assert property (@(posedge clk) disable iff (reset)
        cnt_q <= (PW+1)'(DEPTH)) else $error("Buffer count above depth.");
    c_buf_full: cover property (@(posedge clk) disable iff (reset) !bus.in_ready);
endmodule // vifl_buf

// ---- vifl_buf_if.sv ----
// Valid/ready carrier between the input stage and the two-entry buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface vifl_buf_if #(
    parameter int unsigned W = 30
);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    // The buffer takes words in and hands words out.
    modport buf_side (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    // The owner fills and drains the buffer.
    modport user_side (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data
    );
endinterface // vifl_buf_if

// ---- vifl_pkg.sv ----
// Shared constants and types for the video input and frame latency block.
// Assumes a single 50 MHz clock domain and a synchronous active-high reset.
package vifl_pkg;

    // Clock rate of the block, in hertz.
    localparam int unsigned CLK_HZ = 50_000_000;

    // Width of one colour as it arrives and as it is processed.
    localparam int unsigned IN_BPC   = 12;
    localparam int unsigned PROC_BPC = 10;
    localparam int unsigned CHANNELS = 3;
    localparam int unsigned IN_W     = IN_BPC * CHANNELS;
    localparam int unsigned PROC_W   = PROC_BPC * CHANNELS;
    localparam int unsigned DROP_LSB = IN_BPC - PROC_BPC;

    // Resolution limits, for two-dimensional and per-eye stereo sources.
    localparam int unsigned DIM_W        = 13;
    localparam logic [12:0] MAX_2D_W     = 13'h1000;
    localparam logic [12:0] MAX_2D_H     = 13'h0870;
    localparam logic [12:0] MAX_EYE_W    = 13'h0780;
    localparam logic [12:0] MAX_EYE_H    = 13'h0438;

    // Byte packing modes of the serial video link.
    localparam logic [1:0] BYTE_MODE_3 = 2'h0;
    localparam logic [1:0] BYTE_MODE_4 = 2'h1;
    localparam logic [1:0] BYTE_MODE_5 = 2'h2;

    // Width of the frame ratio and of the latency figures.
    localparam int unsigned RATIO_W = 4;
    localparam int unsigned LAT_W   = 6;
    localparam logic [5:0]  LAT_ZERO = 6'h00;
    localparam logic [5:0]  LAT_ONE  = 6'h01;

    // Kind of source, which selects the processing stages and latency.
    typedef enum logic [4:0] {
        VIFL_ASYNC_UP   = 5'b00001, // Slow progressive graphics, async.
        VIFL_SYNC_GFX   = 5'b00010, // Progressive graphics at display rate.
        VIFL_ASYNC_DOWN = 5'b00100, // Fast progressive graphics, async.
        VIFL_SYNC_UP    = 5'b01000, // Slow progressive video, sync.
        VIFL_SYNC_VID   = 5'b10000  // Progressive video at display rate.
    } vifl_kind_e;

endpackage

// ---- vifl_src_model.sv ----
// Behavioural video source transmitter facing the pixel input of the block.
// Assumes the bench pushes beats after reset and may hold off new beats.
`timescale 1ns/100ps
module vifl_src_model (
    // Clock and pacing.
    input  wire logic                      clk,
    input  wire logic                      hold,
    // Pixel beat toward the block.
    input  wire logic                      pix_ready,
    output      logic                      pix_valid,
    output      logic [vifl_pkg::IN_W-1:0] pix_data,
    output      logic                      pix_sof,
    output      logic                      pix_eol
);
    logic [vifl_pkg::IN_W+1:0] q[$];

    // Queues one beat, marked as frame start and line end as asked.
    task automatic push(input logic [vifl_pkg::IN_W-1:0] d, input logic sof,
                        input logic eol = 1'h0);
        q.push_back({sof, eol, d});
    endtask

    // Nothing is offered at start.
    initial begin
        pix_valid = 1'h0;
        pix_data  = '0;
        pix_sof   = 1'h0;
        pix_eol   = 1'h0;
    end

    // A beat stands until taken; an idle data line toggles every cycle.
    always @(posedge clk) begin
        if (pix_valid && pix_ready) begin
            void'(q.pop_front());
        end
        if ((pix_valid && !pix_ready) || (!hold && q.size() > 0)) begin
            pix_valid <= 1'h1;
            {pix_sof, pix_eol, pix_data} <= q[0];
        end else begin
            pix_valid <= 1'h0;
            pix_sof   <= 1'h0;
            pix_eol   <= 1'h0;
            pix_data  <= ~pix_data;
        end
    end
endmodule // vifl_src_model

// ---- vifl_top.sv ----
// Video input acceptance and frame latency tracking for a display path.
// Assumes all inputs come from logic on clk; display_frame pulses once per
// display frame and source_kind and frame_ratio are steady across a frame.
// Contract
// - Latency is whole frames, chosen by source kind and enabled stages.
// - With unequal rates, async conversion latency changes from frame to frame.
// - Slow async graphics: no deinterlacer, 1..1+N conversion, N formatter.
// - Slow sync video: deinterlacer 1, conversion 1, formatter N, total 2+N.
// - Sync video at display rate: one frame per stage, three in total.
// - Link packs 3, 4 or 5 bytes per unit; other modes refused.
// - Accept up to 4096x2160, stereo eyes up to 1920x1080 frame sequential.
// - N is source frame rate divided by display frame rate.
// - Twelve-bit colours keep upper ten bits, two low bits dropped.
`timescale 1ns/100ps
module vifl_top #(
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset.
    input  wire logic                         clk,
    input  wire logic                         reset,
    // Source configuration.
    input  vifl_pkg::vifl_kind_e              source_kind,
    input  wire logic [vifl_pkg::RATIO_W-1:0] frame_ratio,
    input  wire logic [1:0]                   byte_mode,
    input  wire logic                         bpc12,
    input  wire logic                         stereo,
    // Incoming pixels.
    input  wire logic                         pix_valid,
    output      logic                         pix_ready,
    input  wire logic [vifl_pkg::IN_W-1:0]    pix_data,
    input  wire logic                         pix_sof,
    input  wire logic                         pix_eol,
    // Pixels toward processing.
    output      logic                         out_valid,
    input  wire logic                         out_ready,
    output      logic [vifl_pkg::PROC_W-1:0]  out_data,
    // Display timing and latency report.
    input  wire logic                         display_frame,
    output      logic                         deinterlacer_on,
    output      logic [vifl_pkg::LAT_W-1:0]   frc_frames,
    output      logic [vifl_pkg::LAT_W-1:0]   fmt_frames,
    output      logic [vifl_pkg::LAT_W-1:0]   total_frames,
    // Errors.
    output      logic                         mode_err,
    output      logic                         size_err
);
    localparam int unsigned LW = vifl_pkg::LAT_W;
    localparam int unsigned DW = vifl_pkg::DIM_W;
    localparam logic [5:0]  LAT1 = vifl_pkg::LAT_ONE;

    vifl_buf_if #(.W(vifl_pkg::PROC_W)) bif ();

    logic                      mode_ok, take;
    logic [vifl_pkg::PROC_W-1:0] trunc;
    logic [DW-1:0]             x_q, x_d, y_q, y_d, max_w, max_h;
    logic                      size_err_q, size_err_d, viol;
    vifl_pkg::vifl_kind_e      kind_q, kind_d;
    logic [LW-1:0]             n_q, n_d, ext_q, ext_d;
    logic                      dei_q, dei_d;
    logic [LW-1:0]             frc_q, frc_d, fmt_q, fmt_d;

    // Only the three packing modes are accepted; others hold the link off.
    assign mode_ok = (byte_mode == vifl_pkg::BYTE_MODE_3) ||
                     (byte_mode == vifl_pkg::BYTE_MODE_4) ||
                     (byte_mode == vifl_pkg::BYTE_MODE_5);
    assign pix_ready = mode_ok && bif.in_ready;
    assign take      = pix_valid && pix_ready;
    assign mode_err  = !mode_ok;

    // Colour reduction to ten bits per channel, one slice per channel.
    for (genvar c = 0; c < vifl_pkg::CHANNELS; c++) begin : g_chan
        assign trunc[c*vifl_pkg::PROC_BPC +: vifl_pkg::PROC_BPC] = bpc12 ?
            pix_data[c*vifl_pkg::IN_BPC + vifl_pkg::DROP_LSB +: vifl_pkg::PROC_BPC] :
            pix_data[c*vifl_pkg::PROC_BPC +: vifl_pkg::PROC_BPC];
    end

    // Feed the buffer so a stall at the output backs up to the link.
    assign bif.in_valid  = pix_valid && mode_ok;
    assign bif.in_data   = trunc;
    assign bif.out_ready = out_ready;
    assign out_valid     = bif.out_valid;
    assign out_data      = bif.out_data;

    vifl_buf #(.W(vifl_pkg::PROC_W), .DEPTH(DEPTH)) u_buf (
        .clk   (clk),
        .reset (reset),
        .bus   (bif.buf_side)
    );

    // Size limits depend on whether eyes arrive frame sequentially.
    assign max_w = stereo ? vifl_pkg::MAX_EYE_W : vifl_pkg::MAX_2D_W;
    assign max_h = stereo ? vifl_pkg::MAX_EYE_H : vifl_pkg::MAX_2D_H;

    // Position counters and the oversize flag, which a new frame clears.
    always_comb begin
        x_d  = x_q;
        y_d  = y_q;
        viol = 1'b0;
        if (take) begin
            if (pix_sof) begin
                x_d = DW'(1);
                y_d = '0;
            end else begin
                viol = (x_q >= max_w) || (y_q >= max_h);
                x_d  = (x_q == '1) ? x_q : x_q + 1'b1;
            end
            if (pix_eol) begin
                x_d = '0;
                y_d = (y_d == '1) ? y_d : y_d + 1'b1;
            end
        end
        size_err_d = viol || (size_err_q && !(take && pix_sof));
    end

    // Register position and oversize state.
    always_ff @(posedge clk) begin
        if (reset) begin
            x_q        <= '0;
            y_q        <= '0;
            size_err_q <= 1'b0;
        end else begin
            x_q        <= x_d;
            y_q        <= y_d;
            size_err_q <= size_err_d;
        end
    end
    assign size_err = size_err_q;

    // Per display frame, pick stages and figures from the source kind.
    always_comb begin
        kind_d = kind_q;
        n_d    = n_q;
        ext_d  = ext_q;
        dei_d  = dei_q;
        frc_d  = frc_q;
        fmt_d  = fmt_q;
        if (display_frame) begin
            kind_d = source_kind;
            n_d    = LW'(frame_ratio);
            // The conversion phase walks 0..N so its delay varies.
            ext_d  = (ext_q >= n_d) ? '0 : ext_q + 1'b1;
            case (source_kind)
                vifl_pkg::VIFL_ASYNC_UP: begin
                    dei_d = 1'b0;
                    frc_d = vifl_pkg::LAT_ONE + ext_d;
                    fmt_d = n_d;
                end
                vifl_pkg::VIFL_ASYNC_DOWN: begin
                    dei_d = 1'b0;
                    frc_d = ext_d;
                    fmt_d = n_d;
                end
                vifl_pkg::VIFL_SYNC_UP: begin
                    dei_d = 1'b1;
                    frc_d = vifl_pkg::LAT_ONE;
                    fmt_d = n_d;
                end
                vifl_pkg::VIFL_SYNC_VID: begin
                    dei_d = 1'b1;
                    frc_d = vifl_pkg::LAT_ONE;
                    fmt_d = vifl_pkg::LAT_ONE;
                end
                default: begin
                    dei_d = 1'b0;
                    frc_d = vifl_pkg::LAT_ONE;
                    fmt_d = vifl_pkg::LAT_ONE;
                end
            endcase
        end
    end

    // Register the latency state.
    always_ff @(posedge clk) begin
        if (reset) begin
            kind_q <= vifl_pkg::VIFL_SYNC_GFX;
            n_q    <= vifl_pkg::LAT_ZERO;
            ext_q  <= vifl_pkg::LAT_ZERO;
            dei_q  <= 1'b0;
            frc_q  <= vifl_pkg::LAT_ONE;
            fmt_q  <= vifl_pkg::LAT_ONE;
        end else begin
            kind_q <= kind_d;
            n_q    <= n_d;
            ext_q  <= ext_d;
            dei_q  <= dei_d;
            frc_q  <= frc_d;
            fmt_q  <= fmt_d;
        end
    end

    // Whole-frame total across the three stages.
    assign deinterlacer_on = dei_q;
    assign frc_frames      = frc_q;
    assign fmt_frames      = fmt_q;
    assign total_frames    = LW'(dei_q) + frc_q + fmt_q;

    // Checks on the latency figures and the input stage.
    a_total_sum: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_SYNC_GFX |=>
        !dei_q && frc_q == LAT1 && fmt_q == LAT1 && total_frames == LW'(2))
        else $error("Display-rate graphics latency is not two.");
    a_frc_varies: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_ASYNC_UP &&
        kind_q == vifl_pkg::VIFL_ASYNC_UP && frame_ratio != '0 &&
        LW'(frame_ratio) == n_q |=> frc_q != $past(frc_q))
        else $error("Conversion latency did not change with unequal rates.");
    a_slow_gfx_lat: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_ASYNC_UP |=>
        !dei_q && frc_q >= LAT1 && frc_q <= LAT1 + n_q && fmt_q == n_q)
        else $error("Slow graphics latency out of range.");
    a_slow_vid_lat: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_SYNC_UP |=>
        dei_q && total_frames == LW'(2) + n_q)
        else $error("Slow video latency is not two plus N.");
    a_eq_vid_lat: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_SYNC_VID |=>
        dei_q && frc_q == LAT1 && total_frames == LW'(3))
        else $error("Display-rate video latency is not three.");
    a_fast_gfx_lat: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_ASYNC_DOWN |=>
        !dei_q && frc_q <= n_q && total_frames >= n_q &&
        total_frames <= n_q + n_q)
        else $error("Fast graphics latency out of range.");
    a_mode_refuse: assert property (@(posedge clk) disable iff (reset)
        byte_mode == 2'h3 |-> !pix_ready && mode_err)
        else $error("Pixel taken in an unknown packing mode.");
    a_size_flag: assert property (@(posedge clk) disable iff (reset)
        take && !pix_sof && x_q >= max_w |=> size_err)
        else $error("Oversize line not flagged.");
    a_trunc_bits: assert property (@(posedge clk) disable iff (reset)
        take && bpc12 |-> bif.in_data == {pix_data[35:26], pix_data[23:14],
                                          pix_data[11:2]})
        else $error("Twelve-bit colour not cut to upper ten bits.");
    a_ratio_used: assert property (@(posedge clk) disable iff (reset)
        display_frame && source_kind == vifl_pkg::VIFL_SYNC_UP |=>
        fmt_q == LW'($past(frame_ratio)))
        else $error("Formatter latency does not follow the frame ratio.");

    // Main scenarios worth seeing.
    c_stall_full: cover property (@(posedge clk) disable iff (reset)
        pix_valid && !pix_ready && mode_ok);
    c_slow_gfx: cover property (@(posedge clk) disable iff (reset)
        kind_q == vifl_pkg::VIFL_ASYNC_UP && frc_q > LAT1);
    c_oversize: cover property (@(posedge clk) disable iff (reset) $rose(size_err));
endmodule // vifl_top
